// file: include/tdp_pkg.sv
package tdp_pkg;

  // System clock and flash rates, in hertz and millihertz.
  localparam longint unsigned CLK_HZ = 64'd100000000;
  localparam longint unsigned FAST_FLASH_MHZ = 64'd3760;
  localparam longint unsigned SLOW_FLASH_MHZ = 64'd940;
  localparam longint unsigned SLOW_PER_FAST = FAST_FLASH_MHZ / SLOW_FLASH_MHZ;

  // Counter width and the derived cycle counts.
  localparam int CNT_W = 33;
  typedef logic [CNT_W-1:0] tdp_cnt_t;
  localparam tdp_cnt_t FAST_HALF_CYC =
    tdp_cnt_t'((CLK_HZ * 64'd1000) / (FAST_FLASH_MHZ * 64'd2));
  localparam logic [1:0] SLOW_DIV_LAST = 2'(SLOW_PER_FAST - 64'd1);

  // Power-on time limits in seconds and in cycles.
  localparam longint unsigned CRC_WIN_S = 64'd2;
  localparam longint unsigned SELF_TEST_MAX_S = 64'd60;
  localparam tdp_cnt_t CRC_WIN_CYC = tdp_cnt_t'(CRC_WIN_S * CLK_HZ);
  localparam tdp_cnt_t SELF_TEST_MAX_CYC =
    tdp_cnt_t'(SELF_TEST_MAX_S * CLK_HZ - 64'd1);

  // Servo error pattern: four fast flashes, counted in half periods.
  localparam logic [3:0] SERVO_HALVES = 4'h8;

  // Configuration record and its power-on defaults.
  localparam int BLK_LEN_W = 24;
  typedef struct packed {
    logic densityNative;
    logic bus_parity_check_enable;
    logic even_boundary_disconnect_only;
    logic forbid_disconnect_in_data;
    logic fixedBlock;
    logic [BLK_LEN_W-1:0] blockLen;
  } tdp_cfg_t;
  localparam tdp_cfg_t DEF_CFG = '{
    densityNative: 1'b1,
    bus_parity_check_enable: 1'b1,
    even_boundary_disconnect_only: 1'b0,
    forbid_disconnect_in_data: 1'b0,
    fixedBlock: 1'b1,
    blockLen: 24'h000400
  };

  // Field select bits of a mode-selection update.
  localparam int MS_W = 5;
  localparam int MS_DENSITY = 0;
  localparam int MS_PARITY = 1;
  localparam int MS_EVEN = 2;
  localparam int MS_FORBID = 3;
  localparam int MS_BLOCK = 4;

  typedef enum logic [1:0] {
    UNLD_NORMAL = 2'b00,
    UNLD_FAST = 2'b01,
    UNLD_SUPER = 2'b10
  } tdp_unload_t;
  localparam tdp_unload_t DEF_UNLOAD = UNLD_NORMAL;

  typedef enum logic [1:0] {
    PS_INIT = 2'b00,
    PS_GOFF = 2'b01,
    PS_RUN = 2'b10,
    PS_FAIL = 2'b11
  } tdp_pst_t;

endpackage : tdp_pkg

// file: include/tdp_flash_if.sv
`timescale 1ns/1ps
interface tdp_flash_if;
  logic fastPhase;
  logic slowPhase;
  logic fastTick;
  modport gen (output fastPhase, output slowPhase, output fastTick);
  modport user (input fastPhase, input slowPhase, input fastTick);
endinterface : tdp_flash_if

// file: hw/tdp_flash_gen.sv
`timescale 1ns/1ps
module tdp_flash_gen #(
  parameter tdp_pkg::tdp_cnt_t HALF_CYC = tdp_pkg::FAST_HALF_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Flash phases.
  tdp_flash_if.gen fl
);
  import tdp_pkg::*;

  tdp_cnt_t cnt_q;
  logic [1:0] div_q;
  logic fast_q;
  logic slow_q;
  logic tick_q;
  wire logic wrap = (cnt_q == HALF_CYC - tdp_cnt_t'(1));

  // One timebase counter feeds both rates.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      div_q <= 2'h0;
      fast_q <= 1'b0;
      slow_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + tdp_cnt_t'(1);
      tick_q <= wrap;
      if (wrap) begin
        fast_q <= ~fast_q;
        div_q <= (div_q == SLOW_DIV_LAST) ? 2'h0 : div_q + 2'h1;
        if (div_q == SLOW_DIV_LAST) begin
          slow_q <= ~slow_q;
        end
      end
    end
  end

  assign fl.fastPhase = fast_q;
  assign fl.slowPhase = slow_q;
  assign fl.fastTick = tick_q;

endmodule : tdp_flash_gen

// file: hw/tdp_panel.sv
// Operation
// - Green lit steady while the drive can accept a tape access command.
// - Amber shows both SCSI bus activity and internal errors.
// - Green flashes slowly, 0.94 Hz, during normal tape motion.
// - Green flashes fast, 3.76 Hz, during high-speed search or rewind.
// - Green steady on when a tape is loaded and the drive is ready.
// - Amber follows SCSI data transfer, on while moving, off otherwise.
// - Power-on self-test ends within 60 seconds, with its own pattern.
// - After a pass with no tape, green goes off before amber, both off.
// - Checksum failure shown only in first two seconds; faults any time.
// - Saved configuration values load as defaults at every power-on.
// - A later mode selection replaces the matching stored defaults.
// - Bus parity is checked when its enable is set, enabled by default.
// - Even-boundary setting limits disconnects to even byte counts.
// - No-disconnect setting forbids disconnects during data phases.
// - Block setting picks fixed or variable blocks, default fixed 400h.
// - Density setting picks native or older format, native by default.
// - Writes and erases are refused on a write-protected cartridge.
// - Firmware image picks normal, fast or super fast unload behaviour.
`timescale 1ns/1ps
module tdp_panel #(
  parameter tdp_pkg::tdp_cnt_t FLASH_HALF_CYC = tdp_pkg::FAST_HALF_CYC,
  parameter tdp_pkg::tdp_cnt_t CRC_WIN_CYC = tdp_pkg::CRC_WIN_CYC,
  parameter tdp_pkg::tdp_cnt_t SELF_TEST_MAX_CYC = tdp_pkg::SELF_TEST_MAX_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Front-panel pins.
  input wire logic unloadBtnPin,
  input wire logic writeProtectPin,
  output logic greenLed,
  output logic amberLed,
  // Drive status from the controller.
  input wire logic selfTestBusy,
  input wire logic selfTestPass,
  input wire logic selfTestFail,
  input wire logic tapeLoaded,
  input wire logic driveReady,
  input wire logic tapeMoving,
  input wire logic highSpeedMotion,
  input wire logic scsiDataXfer,
  // Error reports.
  input wire logic servoErr,
  input wire logic unrecovFault,
  input wire logic crcFail,
  input wire logic unloadBtnFail,
  // Stored configuration from the firmware image.
  input wire logic storedCfgSaved,
  input wire tdp_pkg::tdp_cfg_t storedCfg,
  input wire tdp_pkg::tdp_unload_t storedUnloadMode,
  // Mode-selection update.
  input wire logic modeSelStrobe,
  input wire logic [tdp_pkg::MS_W-1:0] modeSelMask,
  input wire tdp_pkg::tdp_cfg_t modeSelCfg,
  // Bus and transfer checks.
  input wire logic busParityErr,
  input wire logic discWanted,
  input wire logic dataPhase,
  input wire logic byteCountOdd,
  input wire logic writeReq,
  input wire logic eraseReq,
  // Results.
  output tdp_pkg::tdp_cfg_t activeCfg,
  output tdp_pkg::tdp_unload_t unloadMode,
  output logic parityErrDetected,
  output logic discAllowed,
  output logic writeAccept,
  output logic writeRefuse,
  output logic unloadReq,
  output logic driveResetReq,
  output logic crcFailShown,
  output logic selfTestFailed
);
  import tdp_pkg::*;

  tdp_flash_if fl ();

  tdp_flash_gen #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .clk(clk),
    .rst_b(rst_b),
    .fl(fl)
  );

  function automatic tdp_cfg_t mergeCfg(input tdp_cfg_t base,
                                        input tdp_cfg_t upd,
                                        input logic [MS_W-1:0] sel);
    tdp_cfg_t r;
    r = base;
    if (sel[MS_DENSITY]) begin
      r.densityNative = upd.densityNative;
    end
    if (sel[MS_PARITY]) begin
      r.bus_parity_check_enable = upd.bus_parity_check_enable;
    end
    if (sel[MS_EVEN]) begin
      r.even_boundary_disconnect_only = upd.even_boundary_disconnect_only;
    end
    if (sel[MS_FORBID]) begin
      r.forbid_disconnect_in_data = upd.forbid_disconnect_in_data;
    end
    if (sel[MS_BLOCK]) begin
      r.fixedBlock = upd.fixedBlock;
      r.blockLen = upd.blockLen;
    end
    return r;
  endfunction : mergeCfg

  // Pin synchronisers.
  logic btnMeta_q;
  logic btnSync_q;
  logic btnPrev_q;
  logic wpMeta_q;
  logic wpSync_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      btnMeta_q <= 1'b0;
      btnSync_q <= 1'b0;
      btnPrev_q <= 1'b0;
      wpMeta_q <= 1'b1;
      wpSync_q <= 1'b1;
    end else begin
      btnMeta_q <= unloadBtnPin;
      btnSync_q <= btnMeta_q;
      btnPrev_q <= btnSync_q;
      wpMeta_q <= writeProtectPin;
      wpSync_q <= wpMeta_q;
    end
  end

  wire logic btnPress = btnSync_q & ~btnPrev_q;

  // Configuration capture after reset release and mode-selection updates.
  logic cfgLoaded_q;
  tdp_cfg_t cfg_q;
  tdp_unload_t unld_q;
  wire tdp_cfg_t powerOnCfg = storedCfgSaved ? storedCfg : DEF_CFG;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgLoaded_q <= 1'b0;
      cfg_q <= DEF_CFG;
      unld_q <= DEF_UNLOAD;
    end else if (!cfgLoaded_q) begin
      cfgLoaded_q <= 1'b1;
      cfg_q <= powerOnCfg;
      unld_q <= storedUnloadMode;
    end else if (modeSelStrobe) begin
      cfg_q <= mergeCfg(cfg_q, modeSelCfg, modeSelMask);
    end
  end

  // Power-on timers for self-test and the checksum window.
  tdp_cnt_t upCnt_q;
  wire logic inCrcWin = (upCnt_q < CRC_WIN_CYC);
  wire logic testTimeout = (upCnt_q >= SELF_TEST_MAX_CYC);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt_q <= '0;
    end else if (!(testTimeout && !inCrcWin)) begin
      upCnt_q <= upCnt_q + tdp_cnt_t'(1);
    end
  end

  // Panel sequence.
  tdp_pst_t pst_q;
  tdp_pst_t pst_d;

  always_comb begin
    pst_d = pst_q;
    case (pst_q)
      PS_INIT: begin
        if (selfTestFail || (selfTestBusy && testTimeout)) begin
          pst_d = PS_FAIL;
        end else if (selfTestPass) begin
          pst_d = PS_GOFF;
        end
      end
      PS_GOFF: begin
        if (fl.fastTick) begin
          pst_d = PS_RUN;
        end
      end
      PS_RUN: pst_d = PS_RUN;
      PS_FAIL: pst_d = PS_FAIL;
      default: pst_d = PS_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_q <= PS_INIT;
    end else begin
      pst_q <= pst_d;
    end
  end

  // Error latches; a new event wins over a clearing press.
  logic servo_q;
  logic fault_q;
  logic crc_q;
  logic btnFail_q;
  logic [3:0] servoHalf_q;
  wire logic errShown = servo_q | fault_q;
  wire logic resetPress = btnPress & errShown;
  wire logic crcSet = crcFail & inCrcWin;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      servo_q <= 1'b0;
      fault_q <= 1'b0;
      crc_q <= 1'b0;
      btnFail_q <= 1'b0;
      servoHalf_q <= 4'h0;
    end else begin
      servo_q <= servoErr | (servo_q & ~resetPress);
      fault_q <= unrecovFault | (fault_q & ~resetPress);
      crc_q <= crc_q | crcSet;
      btnFail_q <= btnFail_q | unloadBtnFail;
      if (servoErr && !servo_q) begin
        servoHalf_q <= 4'h0;
      end else if (servo_q && fl.fastTick && servoHalf_q != SERVO_HALVES) begin
        servoHalf_q <= servoHalf_q + 4'h1;
      end
    end
  end

  // Status pattern for green.
  wire logic canAccept = tapeLoaded & driveReady;
  wire logic motionFast = tapeMoving & highSpeedMotion;
  wire logic motionSlow = tapeMoving & ~highSpeedMotion;
  wire logic greenRun = motionFast ? fl.fastPhase :
                        motionSlow ? fl.slowPhase : canAccept;
  wire logic servoGreen = (servoHalf_q != SERVO_HALVES) & fl.fastPhase;

  logic greenD;
  logic amberD;

  always_comb begin
    greenD = 1'b0;
    amberD = 1'b0;
    if (pst_q == PS_FAIL) begin
      amberD = fl.fastPhase;
    end else if (btnFail_q) begin
      amberD = fl.fastPhase;
      greenD = greenRun;
    end else if (crc_q || fault_q) begin
      amberD = fl.slowPhase;
    end else if (servo_q) begin
      greenD = servoGreen;
      amberD = scsiDataXfer;
    end else begin
      case (pst_q)
        PS_INIT: begin
          greenD = 1'b1;
          amberD = 1'b1;
        end
        PS_GOFF: amberD = 1'b1;
        PS_RUN: begin
          greenD = greenRun;
          amberD = scsiDataXfer;
        end
        default: amberD = 1'b0;
      endcase
    end
  end

  // Bus checks and write protection.
  // Parity when enabled.
  wire logic parityHit = busParityErr & cfg_q.bus_parity_check_enable;
  wire logic evenBlock = cfg_q.even_boundary_disconnect_only & byteCountOdd;
  wire logic dataBlock = cfg_q.forbid_disconnect_in_data & dataPhase;
  wire logic discOk = discWanted & ~evenBlock & ~dataBlock;
  wire logic wrReq = writeReq | eraseReq;

  logic green_q;
  logic amber_q;
  logic parity_q;
  logic disc_q;
  logic wrAcc_q;
  logic wrRef_q;
  logic unldReq_q;
  logic rstReq_q;
  logic failed_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      green_q <= 1'b0;
      amber_q <= 1'b0;
      parity_q <= 1'b0;
      disc_q <= 1'b0;
      wrAcc_q <= 1'b0;
      wrRef_q <= 1'b0;
      unldReq_q <= 1'b0;
      rstReq_q <= 1'b0;
      failed_q <= 1'b0;
    end else begin
      green_q <= greenD;
      amber_q <= amberD;
      parity_q <= parityHit;
      disc_q <= discOk;
      wrAcc_q <= wrReq & ~wpSync_q;
      wrRef_q <= wrReq & wpSync_q;
      unldReq_q <= btnPress & ~errShown;
      rstReq_q <= resetPress;
      failed_q <= (pst_d == PS_FAIL);
    end
  end

  assign greenLed = green_q;
  assign amberLed = amber_q;
  assign activeCfg = cfg_q;
  assign unloadMode = unld_q;
  assign parityErrDetected = parity_q;
  assign discAllowed = disc_q;
  assign writeAccept = wrAcc_q;
  assign writeRefuse = wrRef_q;
  assign unloadReq = unldReq_q;
  assign driveResetReq = rstReq_q;
  assign crcFailShown = crc_q;
  assign selfTestFailed = failed_q;

endmodule : tdp_panel

// file: bench/tdp_operator.sv
`timescale 1ns/1ps
module tdp_operator (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Operator requests.
  input wire logic pressReq,
  input wire logic protectReq,
  // Front-panel pins.
  output logic unloadBtnPin,
  output logic writeProtectPin
);
  logic [2:0] holdCnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdCnt_q <= 3'h0;
    end else if (pressReq) begin
      holdCnt_q <= 3'h4;
    end else if (holdCnt_q != 3'h0) begin
      holdCnt_q <= holdCnt_q - 3'h1;
    end
  end
  assign unloadBtnPin = (holdCnt_q != 3'h0);
  assign writeProtectPin = protectReq;
endmodule : tdp_operator

// file: bench/tdp_panel_sva.sv
`timescale 1ns/1ps
module tdp_panel_sva #(
  parameter tdp_pkg::tdp_cnt_t CRC_WIN_CYC = 50
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched inputs.
  input wire logic unloadBtnPin,
  input wire logic writeProtectPin,
  input wire logic unrecovFault,
  input wire logic busParityErr,
  input wire logic discWanted,
  input wire logic dataPhase,
  input wire logic byteCountOdd,
  input wire logic writeReq,
  input wire logic eraseReq,
  // Watched outputs.
  input wire logic greenLed,
  input wire tdp_pkg::tdp_cfg_t activeCfg,
  input wire logic parityErrDetected,
  input wire logic discAllowed,
  input wire logic writeAccept,
  input wire logic writeRefuse,
  input wire logic unloadReq,
  input wire logic driveResetReq,
  input wire logic crcFailShown,
  input wire logic selfTestFailed
);
  import tdp_pkg::*;
  tdp_cnt_t cycCnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cycCnt_q <= '0;
    end else if (cycCnt_q <= CRC_WIN_CYC + 2) begin
      cycCnt_q <= cycCnt_q + 1'b1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_parity_gate: assert property (
    $past(rst_b) |-> parityErrDetected ==
      $past(busParityErr && activeCfg.bus_parity_check_enable))
    else $error("parity detect mismatch");
  chk_disc_gate: assert property (
    $past(rst_b) |-> discAllowed == $past(discWanted
      && !(activeCfg.even_boundary_disconnect_only && byteCountOdd)
      && !(activeCfg.forbid_disconnect_in_data && dataPhase)))
    else $error("disconnect permission mismatch");
  chk_write_refuse: assert property (
    (writeReq || eraseReq) && $past(writeProtectPin, 2)
      && $past(writeProtectPin, 3) |=> writeRefuse && !writeAccept)
    else $error("protected write not refused");
  chk_write_accept: assert property (
    writeAccept |-> $past(writeReq || eraseReq)
      && !($past(writeProtectPin, 3) && $past(writeProtectPin, 4)))
    else $error("write accepted while protected");
  chk_fault_green: assert property (
    unrecovFault |-> ##2 !greenLed)
    else $error("green lit during fault");
  chk_fail_green: assert property (
    selfTestFailed |=> !greenLed)
    else $error("green lit after self-test failure");
  chk_press_answer: assert property (
    $rose(unloadBtnPin) |-> ##3 (unloadReq || driveResetReq))
    else $error("button press not answered");
  chk_crc_window: assert property (
    $rose(crcFailShown) |-> cycCnt_q <= CRC_WIN_CYC + 2)
    else $error("checksum failure shown late");
endmodule : tdp_panel_sva

bind tdp_panel tdp_panel_sva #(.CRC_WIN_CYC(CRC_WIN_CYC)) u_tdp_panel_sva (
  .clk(clk), .rst_b(rst_b), .unloadBtnPin(unloadBtnPin),
  .writeProtectPin(writeProtectPin), .unrecovFault(unrecovFault),
  .busParityErr(busParityErr), .discWanted(discWanted),
  .dataPhase(dataPhase), .byteCountOdd(byteCountOdd), .writeReq(writeReq),
  .eraseReq(eraseReq), .greenLed(greenLed), .activeCfg(activeCfg),
  .parityErrDetected(parityErrDetected), .discAllowed(discAllowed),
  .writeAccept(writeAccept), .writeRefuse(writeRefuse),
  .unloadReq(unloadReq), .driveResetReq(driveResetReq),
  .crcFailShown(crcFailShown), .selfTestFailed(selfTestFailed)
);

// file: bench/tdp_panel_test.sv
`timescale 1ns/1ps
module tdp_panel_test;
  import tdp_pkg::*;
  localparam int HALF = 4;
  logic clk = 1'b0, rst_b = 1'b0, pressReq = 1'b0, protectReq = 1'b0;
  logic unloadBtnPin, writeProtectPin, greenLed, amberLed;
  logic selfTestBusy, selfTestPass, selfTestFail, tapeLoaded, driveReady;
  logic tapeMoving, highSpeedMotion, scsiDataXfer, servoErr, unrecovFault;
  logic crcFail, unloadBtnFail, storedCfgSaved, modeSelStrobe, eraseReq;
  logic busParityErr, discWanted, dataPhase, byteCountOdd, writeReq;
  logic parityErrDetected, discAllowed, writeAccept, writeRefuse, unloadReq;
  logic driveResetReq, crcFailShown, selfTestFailed;
  logic [MS_W-1:0] modeSelMask;
  tdp_cfg_t storedCfg, modeSelCfg, activeCfg, expCfg;
  tdp_unload_t storedUnloadMode, unloadMode;
  int failures = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  tdp_operator u_tdp_operator (.clk(clk), .rst_b(rst_b), .pressReq(pressReq),
    .protectReq(protectReq), .unloadBtnPin(unloadBtnPin),
    .writeProtectPin(writeProtectPin));
  tdp_panel #(.FLASH_HALF_CYC(HALF), .CRC_WIN_CYC(50),
    .SELF_TEST_MAX_CYC(100)) u_tdp_panel (.clk(clk), .rst_b(rst_b),
    .unloadBtnPin(unloadBtnPin), .writeProtectPin(writeProtectPin),
    .greenLed(greenLed), .amberLed(amberLed), .selfTestBusy(selfTestBusy),
    .selfTestPass(selfTestPass), .selfTestFail(selfTestFail),
    .tapeLoaded(tapeLoaded), .driveReady(driveReady), .tapeMoving(tapeMoving),
    .highSpeedMotion(highSpeedMotion), .scsiDataXfer(scsiDataXfer),
    .servoErr(servoErr), .unrecovFault(unrecovFault), .crcFail(crcFail),
    .unloadBtnFail(unloadBtnFail), .storedCfgSaved(storedCfgSaved),
    .storedCfg(storedCfg), .storedUnloadMode(storedUnloadMode),
    .modeSelStrobe(modeSelStrobe), .modeSelMask(modeSelMask),
    .modeSelCfg(modeSelCfg), .busParityErr(busParityErr),
    .discWanted(discWanted), .dataPhase(dataPhase),
    .byteCountOdd(byteCountOdd), .writeReq(writeReq), .eraseReq(eraseReq),
    .activeCfg(activeCfg), .unloadMode(unloadMode),
    .parityErrDetected(parityErrDetected), .discAllowed(discAllowed),
    .writeAccept(writeAccept), .writeRefuse(writeRefuse),
    .unloadReq(unloadReq), .driveResetReq(driveResetReq),
    .crcFailShown(crcFailShown), .selfTestFailed(selfTestFailed));
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_vec(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    cycles(5);
    rst_b = 1'b1;
  endtask : do_reset
  task automatic mode_sel(input logic [MS_W-1:0] mask, input tdp_cfg_t cfg);
    @(negedge clk);
    modeSelStrobe = 1'b1;
    modeSelMask = mask;
    modeSelCfg = cfg;
    cycles(1);
    modeSelStrobe = 1'b0;
    cycles(1);
  endtask : mode_sel
  task automatic parity_op(input logic exp);
    @(negedge clk);
    busParityErr = 1'b1;
    cycles(1);
    busParityErr = 1'b0;
    chk_bit("parityErrDetected", exp, parityErrDetected);
    cycles(1);
  endtask : parity_op
  task automatic write_op(input logic erase, input logic exp);
    @(negedge clk);
    writeReq = !erase;
    eraseReq = erase;
    cycles(1);
    writeReq = 1'b0;
    eraseReq = 1'b0;
    chk_bit("writeAccept", exp, writeAccept);
    chk_bit("writeRefuse", !exp, writeRefuse);
    cycles(1);
  endtask : write_op
  task automatic disc_scan(input logic even, input logic forbid);
    for (int i = 0; i < 8; i++) begin
      {discWanted, dataPhase, byteCountOdd} = 3'(i);
      cycles(2);
      chk_bit("discAllowed", discWanted && !(even && byteCountOdd)
        && !(forbid && dataPhase), discAllowed);
    end
  endtask : disc_scan
  task automatic press(input logic expReset);
    logic sawR;
    logic sawU;
    sawR = 1'b0;
    sawU = 1'b0;
    @(negedge clk);
    pressReq = 1'b1;
    cycles(1);
    pressReq = 1'b0;
    repeat (10) begin
      @(negedge clk);
      sawR = sawR | driveResetReq;
      sawU = sawU | unloadReq;
    end
    chk_bit("driveResetReq", expReset, sawR);
    chk_bit("unloadReq", !expReset, sawU);
  endtask : press
  task automatic half_gap(input logic amber, input int exp);
    logic g;
    int n;
    for (int k = 0; k < 3; k++) begin
      g = amber ? amberLed : greenLed;
      n = 0;
      while ((amber ? amberLed : greenLed) === g && n < 40) begin
        @(negedge clk);
        n++;
      end
    end
    chk_vec("ledHalfPeriod", exp, n);
  endtask : half_gap
  initial begin
    {selfTestBusy, selfTestPass, selfTestFail, tapeLoaded, driveReady,
      tapeMoving, highSpeedMotion, scsiDataXfer, servoErr, unrecovFault,
      crcFail, unloadBtnFail, storedCfgSaved, modeSelStrobe, eraseReq,
      busParityErr, discWanted, dataPhase, byteCountOdd, writeReq} = '0;
    modeSelMask = '0;
    modeSelCfg = DEF_CFG;
    storedCfg = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 24'h000123};
    storedUnloadMode = UNLD_NORMAL;
    for (int m = 0; m < 3; m++) begin
      storedCfgSaved = (m != 0);
      storedUnloadMode = tdp_unload_t'(m);
      do_reset();
      cycles(3);
      expCfg = (m != 0) ? storedCfg : DEF_CFG;
      chk_vec("activeCfg", 32'(expCfg), 32'(activeCfg));
      chk_vec("unloadMode", 32'(m), 32'(unloadMode));
      chk_bit("greenLed", 1'b1, greenLed);
      chk_bit("amberLed", 1'b1, amberLed);
    end
    $display("Test power-on defaults done");
    disc_scan(1'b1, 1'b1);
    expCfg.bus_parity_check_enable = 1'b1;
    expCfg.fixedBlock = 1'b1;
    expCfg.blockLen = 24'h000400;
    mode_sel(5'h12, DEF_CFG);
    chk_vec("activeCfg", 32'(expCfg), 32'(activeCfg));
    parity_op(1'b1);
    mode_sel(5'h0D, DEF_CFG);
    chk_vec("activeCfg", 32'(DEF_CFG), 32'(activeCfg));
    disc_scan(1'b0, 1'b0);
    mode_sel(5'h02, storedCfg);
    parity_op(1'b0);
    cycles(4);
    write_op(1'b0, 1'b1);
    write_op(1'b1, 1'b1);
    protectReq = 1'b1;
    cycles(4);
    write_op(1'b0, 1'b0);
    write_op(1'b1, 1'b0);
    $display("Test configuration and transfer done");
    selfTestPass = 1'b1;
    cycles(1);
    selfTestPass = 1'b0;
    cycles(12);
    chk_bit("greenLed", 1'b0, greenLed);
    chk_bit("amberLed", 1'b0, amberLed);
    tapeLoaded = 1'b1;
    driveReady = 1'b1;
    scsiDataXfer = 1'b1;
    cycles(3);
    chk_bit("greenLed", 1'b1, greenLed);
    chk_bit("amberLed", 1'b1, amberLed);
    driveReady = 1'b0;
    scsiDataXfer = 1'b0;
    cycles(3);
    chk_bit("greenLed", 1'b0, greenLed);
    chk_bit("amberLed", 1'b0, amberLed);
    tapeMoving = 1'b1;
    half_gap(1'b0, HALF * int'(SLOW_PER_FAST));
    highSpeedMotion = 1'b1;
    half_gap(1'b0, HALF);
    {tapeMoving, highSpeedMotion, driveReady} = 3'b001;
    $display("Test indicators done");
    servoErr = 1'b1;
    cycles(1);
    servoErr = 1'b0;
    press(1'b1);
    press(1'b0);
    unrecovFault = 1'b1;
    cycles(1);
    unrecovFault = 1'b0;
    cycles(3);
    chk_bit("greenLed", 1'b0, greenLed);
    press(1'b1);
    cycles(3);
    chk_bit("greenLed", 1'b1, greenLed);
    crcFail = 1'b1;
    cycles(1);
    crcFail = 1'b0;
    cycles(2);
    chk_bit("crcFailShown", 1'b0, crcFailShown);
    $display("Test errors and button done");
    do_reset();
    cycles(5);
    crcFail = 1'b1;
    cycles(1);
    crcFail = 1'b0;
    cycles(2);
    chk_bit("crcFailShown", 1'b1, crcFailShown);
    chk_bit("greenLed", 1'b0, greenLed);
    half_gap(1'b1, HALF * int'(SLOW_PER_FAST));
    unloadBtnFail = 1'b1;
    cycles(1);
    unloadBtnFail = 1'b0;
    half_gap(1'b1, HALF);
    chk_bit("greenLed", 1'b1, greenLed);
    selfTestBusy = 1'b1;
    do_reset();
    cycles(120);
    chk_bit("selfTestFailed", 1'b1, selfTestFailed);
    chk_bit("greenLed", 1'b0, greenLed);
    half_gap(1'b1, HALF);
    selfTestBusy = 1'b0;
    do_reset();
    selfTestFail = 1'b1;
    cycles(1);
    selfTestFail = 1'b0;
    cycles(3);
    chk_bit("selfTestFailed", 1'b1, selfTestFailed);
    $display("Test power-on checks done");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("Watchdog expired");
    end_of_test();
  end
endmodule : tdp_panel_test
